/* File: core/bmf_pkg.sv */
// shared constants and types of the bus-matching fifo core and its avalon slave
package bmf_pkg;
   // long word width held in memory
   localparam int BMF_DATA_W = 36;
   // flop stages of each flag synchroniser path
   localparam int BMF_SYNC_STAGES = 2;
   // register byte offsets on the avalon slave
   localparam logic [3:0] BMF_CTRL_OFS = 4'h0;
   localparam logic [3:0] BMF_STAT_OFS = 4'h4;
   localparam logic [3:0] BMF_OFFS_OFS = 4'h8;
   // control field positions
   localparam int BMF_CTRL_BM_BIT   = 0;
   localparam int BMF_CTRL_SIZE_BIT = 1;
   localparam logic [1:0] BMF_CTRL_RST = 2'h0;
   // status field positions
   localparam int BMF_STAT_EOR_BIT  = 0;
   localparam int BMF_STAT_FIR_BIT  = 1;
   localparam int BMF_STAT_FALLTHROUGH_MODE_BIT = 2;
   localparam int BMF_STAT_END_BIT  = 3;
   localparam int BMF_STAT_PROG_BIT = 4;
   localparam int BMF_STAT_LVL_POS  = 16;
   // offset register: almost-full offset sits high
   localparam int BMF_OFFS_AF_POS = 16;
   // offset programming method chosen at master reset
   localparam logic [1:0] BMF_PM_DEFAULT  = 2'h0;
   localparam logic [1:0] BMF_PM_SERIAL   = 2'h1;
   localparam logic [1:0] BMF_PM_PARALLEL = 2'h2;
   // avalon answer timing: one wait cycle
   localparam logic BMF_WAIT_RST = 1'b1;

   typedef enum logic [2:0] {
      BMF_ST_RESET = 3'b001,
      BMF_ST_PROG  = 3'b010,
      BMF_ST_RUN   = 3'b100
   } bmf_state_t;

   // configuration latched at master reset release
   typedef struct packed {
      logic bus_match;
      logic size;
      logic endian;
      logic fallthrough_mode;
   } bmf_cfg_t;

   localparam bmf_cfg_t BMF_CFG_RST = '{1'b0, 1'b0, 1'b0, 1'b0};
endpackage

/* File: core/bmf_fifo.sv */
// bus-matching fifo: long word store, narrowing read port and flags
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// [R1] select high: flag drops one cycle sooner
// [R2] master reset held high during flush
// [R3] flush held high during master reset
// [R4] writes ignored while programming; serial bits sparse
// [R5] serial order: almost-full offset, then almost-empty
// [R6] parallel load: select low, write high, mailbox low
// [R7] parallel offset writes need not be consecutive
// [R8] long-word mode passes word unchanged
// [R9] word mode: two reads, endian picks half
// [R10] word mode: bits 35..18 undefined
// [R11] byte mode: four reads, endian picks byte
// [R12] byte mode: bits 35..9 undefined
// [R13] endian latched at reset; sizes static
// [R14] fall-through: first word out within three
// [R15] flag drops only on final part
// [R16] standard: empty flag rises after sync
// [R17] fall-through: input ready rises after sync
// [R18] full sync starts from final part read
// [R19] endian captured on master reset release
// [R20] memory read whole; remainder held aside
// [R21] flags cross through two flops
// [R22] flush clears data, keeps configuration
module bmf_fifo #(
   parameter int DEPTH      = 256,
   parameter int DEF_OFFSET = 8
) (
   // clock and system reset
   input  wire logic                         clk,
   input  wire logic                         rst,
   // avalon-mm register slave
   input  wire logic [3:0]                   avs_address,
   input  wire logic                         avs_read,
   input  wire logic                         avs_write,
   input  wire logic [31:0]                  avs_writedata,
   output logic      [31:0]                  avs_readdata,
   output logic                              avs_waitrequest,
   // device reset and configuration pins
   input  wire logic                         master_reset_n,
   input  wire logic                         flush_reset_n,
   input  wire logic                         endian_fallthrough_select,
   input  wire logic [1:0]                   offset_mode_select,
   input  wire logic                         serial_offset_in,
   input  wire logic                         serial_offset_enable,
   // write port
   input  wire logic                         porta_select_n,
   input  wire logic                         porta_write_read,
   input  wire logic                         porta_enable,
   input  wire logic                         porta_mailbox_select,
   input  wire logic [bmf_pkg::BMF_DATA_W-1:0] porta_data,
   // read port
   input  wire logic                         portb_read_enable,
   output logic      [bmf_pkg::BMF_DATA_W-1:0] portb_data,
   // flags
   output logic                              empty_or_output_ready,
   output logic                              full_or_input_ready
);
   localparam int AW  = $clog2(DEPTH);
   localparam int OW  = AW;
   localparam int SCW = $clog2(2 * OW) + 1;
   localparam logic [AW:0]    FULL_CNT = (AW + 1)'(DEPTH);
   localparam logic [OW-1:0]  OFS_DEF  = OW'(DEF_OFFSET);
   localparam logic [SCW-1:0] SER_LAST = SCW'(2 * OW - 1);

   logic [bmf_pkg::BMF_DATA_W-1:0] mem [DEPTH];

   bmf_pkg::bmf_state_t state_q, state_d;
   bmf_pkg::bmf_cfg_t   cfg_q, cfg_d;
   logic [1:0]          pmode_q, pmode_d;
   logic [AW:0]         wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
   logic [AW:0]         rel_ptr_q, rel_ptr_d;
   logic [AW:0]         wr_s1_q, wr_s1_d, wr_s2_q, wr_s2_d;
   logic [AW:0]         rel_s1_q, rel_s1_d, rel_s2_q, rel_s2_d;
   logic [bmf_pkg::BMF_DATA_W-1:0] hold_q, hold_d, out_q, out_d;
   logic [1:0]          part_q, part_d;
   logic                eor_q, eor_d, fir_q, fir_d;
   logic                mrst_prev_q, mrst_prev_d, in_rst_q, in_rst_d;
   logic [OW-1:0]       af_q, af_d, ae_q, ae_d;
   logic [SCW-1:0]      sh_cnt_q, sh_cnt_d;
   logic                par_cnt_q, par_cnt_d;
   logic                mem_we;
   logic [1:0]          ctrl_q, ctrl_d;
   logic [31:0]         rdata_q, rdata_d;
   logic                wait_q, wait_d;

   // pick one bus-width unit of a long word for read number idx
   function automatic logic [bmf_pkg::BMF_DATA_W-1:0] bmf_slice(
      input logic [bmf_pkg::BMF_DATA_W-1:0] w,
      input bmf_pkg::bmf_cfg_t             c,
      input logic [1:0]                    idx
   );
      logic [1:0]                     lane;
      logic [bmf_pkg::BMF_DATA_W-1:0] r;
      r    = '0;
      lane = c.endian ? 2'h3 - idx : idx;
      if (!c.bus_match) begin
         r = w; // R8
      end else if (!c.size) begin
         // unused upper lanes read zero rather than stale bits
         r[17:0] = (idx[0] ^ ~c.endian) ? w[17:0] : w[35:18]; // R9 R10
      end else begin
         r[8:0] = w[(32'(lane) * 9) +: 9]; // R11 R12
      end
      return r;
   endfunction

   // index of the final unit of a long word in the latched size
   function automatic logic [1:0] bmf_last(input bmf_pkg::bmf_cfg_t c);
      return !c.bus_match ? 2'h0 : (!c.size ? 2'h1 : 2'h3);
   endfunction

   logic                           mrst, frst, any_rst, mrst_rise;
   logic                           wr_req, can_get, take, rd_strobe;
   logic [bmf_pkg::BMF_DATA_W-1:0] src;

   // fifo core: reset sequencing, programming, write, read, flags
   always_comb begin
      state_d     = state_q;
      cfg_d       = cfg_q;
      pmode_d     = pmode_q;
      wr_ptr_d    = wr_ptr_q;
      rd_ptr_d    = rd_ptr_q;
      rel_ptr_d   = rel_ptr_q;
      hold_d      = hold_q;
      out_d       = out_q;
      part_d      = part_q;
      eor_d       = eor_q;
      af_d        = af_q;
      ae_d        = ae_q;
      sh_cnt_d    = sh_cnt_q;
      par_cnt_d   = par_cnt_q;
      mem_we      = 1'b0;
      mrst        = ~master_reset_n;
      frst        = ~flush_reset_n;
      any_rst     = mrst | frst;
      mrst_rise   = mrst_prev_q & ~mrst;
      mrst_prev_d = mrst;
      in_rst_d    = any_rst;
      // a two-stage path stands in for the clock-domain sync
      wr_s1_d     = wr_ptr_q;  // R21
      wr_s2_d     = wr_s1_q;
      rel_s1_d    = rel_ptr_q;
      rel_s2_d    = rel_s1_q;
      wr_req      = ~porta_select_n & porta_write_read & porta_enable &
                    ~porta_mailbox_select; // R6
      rd_strobe   = portb_read_enable & ~any_rst;
      src         = (part_q != 2'h0) ? hold_q : mem[rd_ptr_q[AW-1:0]];
      can_get     = (part_q != 2'h0) || (wr_s2_q != rd_ptr_q);
      take        = 1'b0;
      if (mrst_rise) begin
         // sizes from ctrl, endian and mode from the shared pin
         cfg_d.bus_match = ctrl_q[bmf_pkg::BMF_CTRL_BM_BIT];  // R13
         cfg_d.size      = ctrl_q[bmf_pkg::BMF_CTRL_SIZE_BIT];
         cfg_d.endian    = endian_fallthrough_select; // R19
         cfg_d.fallthrough_mode      = endian_fallthrough_select;
         pmode_d         = offset_mode_select;
         sh_cnt_d        = '0;
         par_cnt_d       = 1'b0;
         if (offset_mode_select == bmf_pkg::BMF_PM_DEFAULT) begin
            af_d    = OFS_DEF;
            ae_d    = OFS_DEF;
            state_d = bmf_pkg::BMF_ST_RUN;
         end else begin
            state_d = bmf_pkg::BMF_ST_PROG;
         end
      end
      if (mrst) begin
         state_d = bmf_pkg::BMF_ST_RESET;
      end
      if (state_q == bmf_pkg::BMF_ST_PROG && !any_rst) begin
         // sparse strobes; fifo writes are dropped meanwhile
         if (pmode_q == bmf_pkg::BMF_PM_SERIAL) begin
            if (serial_offset_enable) begin // R4
               {af_d, ae_d} = {af_q[OW-2:0], ae_q, serial_offset_in}; // R5
               sh_cnt_d     = sh_cnt_q + SCW'(1);
               if (sh_cnt_q == SER_LAST) begin
                  state_d = bmf_pkg::BMF_ST_RUN;
               end
            end
         end else if (wr_req) begin // R7
            par_cnt_d = 1'b1;
            if (!par_cnt_q) begin
               af_d = porta_data[OW-1:0];
            end else begin
               ae_d    = porta_data[OW-1:0];
               state_d = bmf_pkg::BMF_ST_RUN;
            end
         end
      end
      // long word writes only once input ready shows
      if (state_q == bmf_pkg::BMF_ST_RUN && !any_rst && wr_req && fir_q) begin
         mem_we   = 1'b1; // R4
         wr_ptr_d = wr_ptr_q + (AW + 1)'(1);
      end
      // standard reads need a strobe; fall-through preloads
      if (cfg_q.fallthrough_mode) begin
         take = can_get && (!eor_q || rd_strobe); // R14
         if (rd_strobe && eor_q && !can_get) begin
            eor_d = 1'b0;
         end
      end else begin
         take = rd_strobe && eor_q && can_get;
      end
      if (take && !any_rst) begin
         out_d = bmf_slice(src, cfg_q, part_q);
         if (part_q == 2'h0) begin
            hold_d   = src; // R20
            rd_ptr_d = rd_ptr_q + (AW + 1)'(1);
         end
         if (part_q == bmf_last(cfg_q)) begin
            part_d    = 2'h0;
            rel_ptr_d = rel_ptr_q + (AW + 1)'(1); // R18
         end else begin
            part_d = part_q + 2'h1;
         end
         if (cfg_q.fallthrough_mode) begin
            eor_d = 1'b1;
         end
      end
      if (!cfg_q.fallthrough_mode) begin
         // stays high while any part or word is left
         eor_d = (part_d != 2'h0) || (wr_s2_q != rd_ptr_d); // R15 R16
      end
      // flush empties data but leaves cfg and offsets alone
      if (any_rst) begin
         wr_ptr_d  = '0; // R22
         rd_ptr_d  = '0;
         rel_ptr_d = '0;
         wr_s1_d   = '0;
         wr_s2_d   = '0;
         rel_s1_d  = '0;
         rel_s2_d  = '0;
         part_d    = 2'h0;
         // low select holds the flag one extra cycle
         eor_d = (!in_rst_q && !endian_fallthrough_select) ? eor_q : 1'b0; // R1
      end
      fir_d = (state_d == bmf_pkg::BMF_ST_RUN) && !any_rst &&
              ((wr_ptr_d - rel_s2_q) != FULL_CNT); // R17 R21
   end

   // core registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q     <= bmf_pkg::BMF_ST_RESET;
         cfg_q       <= bmf_pkg::BMF_CFG_RST;
         pmode_q     <= bmf_pkg::BMF_PM_DEFAULT;
         wr_ptr_q    <= '0;
         rd_ptr_q    <= '0;
         rel_ptr_q   <= '0;
         wr_s1_q     <= '0;
         wr_s2_q     <= '0;
         rel_s1_q    <= '0;
         rel_s2_q    <= '0;
         hold_q      <= '0;
         out_q       <= '0;
         part_q      <= 2'h0;
         eor_q       <= 1'b0;
         fir_q       <= 1'b0;
         mrst_prev_q <= 1'b0;
         in_rst_q    <= 1'b0;
         af_q        <= '0;
         ae_q        <= '0;
         sh_cnt_q    <= '0;
         par_cnt_q   <= 1'b0;
      end else begin
         state_q     <= state_d;
         cfg_q       <= cfg_d;
         pmode_q     <= pmode_d;
         wr_ptr_q    <= wr_ptr_d;
         rd_ptr_q    <= rd_ptr_d;
         rel_ptr_q   <= rel_ptr_d;
         wr_s1_q     <= wr_s1_d;
         wr_s2_q     <= wr_s2_d;
         rel_s1_q    <= rel_s1_d;
         rel_s2_q    <= rel_s2_d;
         hold_q      <= hold_d;
         out_q       <= out_d;
         part_q      <= part_d;
         eor_q       <= eor_d;
         fir_q       <= fir_d;
         mrst_prev_q <= mrst_prev_d;
         in_rst_q    <= in_rst_d;
         af_q        <= af_d;
         ae_q        <= ae_d;
         sh_cnt_q    <= sh_cnt_d;
         par_cnt_q   <= par_cnt_d;
      end
   end

   // storage array carries no reset to stay ram-like
   always_ff @(posedge clk) begin
      if (mem_we) begin
         mem[wr_ptr_q[AW-1:0]] <= porta_data;
      end
   end

   // avalon slave: one wait cycle, then data or write effect
   always_comb begin
      ctrl_d  = ctrl_q;
      rdata_d = rdata_q;
      wait_d  = bmf_pkg::BMF_WAIT_RST;
      if ((avs_read || avs_write) && wait_q) begin
         wait_d  = 1'b0;
         rdata_d = 32'h0;
         if (avs_read) begin
            case (avs_address)
               bmf_pkg::BMF_CTRL_OFS: begin
                  rdata_d[1:0] = ctrl_q;
               end
               bmf_pkg::BMF_STAT_OFS: begin
                  rdata_d[bmf_pkg::BMF_STAT_EOR_BIT]  = eor_q;
                  rdata_d[bmf_pkg::BMF_STAT_FIR_BIT]  = fir_q;
                  rdata_d[bmf_pkg::BMF_STAT_FALLTHROUGH_MODE_BIT] = cfg_q.fallthrough_mode;
                  rdata_d[bmf_pkg::BMF_STAT_END_BIT]  = cfg_q.endian;
                  rdata_d[bmf_pkg::BMF_STAT_PROG_BIT] =
                     (state_q == bmf_pkg::BMF_ST_PROG);
                  rdata_d[bmf_pkg::BMF_STAT_LVL_POS +: AW + 1] =
                     wr_ptr_q - rel_ptr_q;
               end
               bmf_pkg::BMF_OFFS_OFS: begin
                  rdata_d[OW-1:0] = ae_q;
                  rdata_d[bmf_pkg::BMF_OFFS_AF_POS +: OW] = af_q;
               end
               default: begin
                  rdata_d = 32'h0;
               end
            endcase
         end
      end
      // sizes only take effect at the next master reset release
      if (avs_write && !wait_q && avs_address == bmf_pkg::BMF_CTRL_OFS) begin
         ctrl_d = avs_writedata[1:0];
      end
   end

   // avalon registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q  <= bmf_pkg::BMF_CTRL_RST;
         rdata_q <= 32'h0;
         wait_q  <= bmf_pkg::BMF_WAIT_RST;
      end else begin
         ctrl_q  <= ctrl_d;
         rdata_q <= rdata_d;
         wait_q  <= wait_d;
      end
   end

   // outputs straight from flops
   assign avs_readdata          = rdata_q;
   assign avs_waitrequest       = wait_q;
   assign portb_data            = out_q;
   assign empty_or_output_ready = eor_q;
   assign full_or_input_ready   = fir_q;
endmodule

`default_nettype wire

/* File: dv/bmf_fifo_properties.sv */
// timing checker for the fifo flag, reset and register bus ports
`timescale 1ns/10ps
`default_nettype none
module bmf_fifo_props (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // register bus
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // reset and select pins
   input wire logic        master_reset_n,
   input wire logic        flush_reset_n,
   input wire logic        endian_fallthrough_select,
   // data ports and flags
   input wire logic        porta_select_n,
   input wire logic        porta_write_read,
   input wire logic        porta_enable,
   input wire logic        porta_mailbox_select,
   input wire logic        portb_read_enable,
   input wire logic [35:0] portb_data,
   input wire logic        empty_or_output_ready,
   input wire logic        full_or_input_ready
);
   logic mr_q;
   logic fw_q;
   logic wr_take;
   // accepted fifo write, never while a reset pin is low
   assign wr_take = !porta_select_n && porta_write_read && porta_enable
      && !porta_mailbox_select && full_or_input_ready
      && master_reset_n && flush_reset_n;
   // mode as taken at master reset release, the design hides it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mr_q <= 1'b1; // pin idles high, no false release after rst
         fw_q <= 1'b0;
      end else begin
         mr_q <= master_reset_n;
         if (master_reset_n && !mr_q) begin
            fw_q <= endian_fallthrough_select;
         end
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_eor_fast_drop: assert property (
      ($fell(master_reset_n) || $fell(flush_reset_n))
      && endian_fallthrough_select |=> !empty_or_output_ready)
      else $error("flag not low one cycle into reset");
   a_eor_slow_drop: assert property (
      ($fell(master_reset_n) || $fell(flush_reset_n))
      && !endian_fallthrough_select && empty_or_output_ready
      |=> empty_or_output_ready ##1 !empty_or_output_ready)
      else $error("flag timing wrong in slow reset");
   a_reset_clears: assert property (
      (!master_reset_n || !flush_reset_n) [*3]
      |-> !empty_or_output_ready && !full_or_input_ready)
      else $error("flags not cleared by reset");
   a_first_word: assert property (
      wr_take && !empty_or_output_ready
      |=> !empty_or_output_ready ##[1:3] empty_or_output_ready)
      else $error("first word flag timing wrong");
   a_out_hold: assert property (
      !fw_q && !portb_read_enable && master_reset_n && flush_reset_n
      |=> $stable(portb_data))
      else $error("output register moved without a read");
   a_wait_answer: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer not after one wait cycle");
   a_wait_single: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("wait low for more than one cycle");
   a_unmapped_zero: assert property (
      avs_read && !avs_waitrequest
      && !(avs_address inside {4'h0, 4'h4, 4'h8})
      |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
endmodule
bind bmf_fifo bmf_fifo_props u_bmf_fifo_props (
   .clk(clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .master_reset_n(master_reset_n), .flush_reset_n(flush_reset_n),
   .endian_fallthrough_select(endian_fallthrough_select),
   .porta_select_n(porta_select_n), .porta_write_read(porta_write_read),
   .porta_enable(porta_enable),
   .porta_mailbox_select(porta_mailbox_select),
   .portb_read_enable(portb_read_enable), .portb_data(portb_data),
   .empty_or_output_ready(empty_or_output_ready),
   .full_or_input_ready(full_or_input_ready)
);
`default_nettype wire

/* File: dv/bmf_porta_master.sv */
// port a bus master that writes long words into the fifo
`timescale 1ns/10ps
`default_nettype none
module bmf_porta_master (
   // clock and flag
   input  wire logic        clk,
   input  wire logic        full_or_input_ready,
   // port a request
   output logic             porta_select_n,
   output logic             porta_write_read,
   output logic             porta_enable,
   output logic             porta_mailbox_select,
   output logic [35:0]      porta_data
);
   // fifo path only: write high, mailbox low
   initial begin
      porta_select_n = 1'b1;
      porta_write_read = 1'b1;
      porta_enable = 1'b0;
      porta_mailbox_select = 1'b0;
      porta_data = 36'h0;
   end
   // hold until an edge sees room unless told not to wait
   task automatic put(input logic [35:0] w, input bit hold);
      porta_select_n <= 1'b0;
      porta_enable <= 1'b1;
      porta_data <= w;
      @(posedge clk);
      while (hold && full_or_input_ready !== 1'b1) @(posedge clk);
      porta_select_n <= 1'b1;
      porta_enable <= 1'b0;
      porta_data <= ~w; // stale data must not look valid
   endtask
endmodule
`default_nettype wire

/* File: dv/tb_bmf_fifo.sv */
// bench: offsets, every bus size and endian, flush
`timescale 1ns/10ps
`default_nettype none
module tb_bmf_fifo;
   logic        clk, rst, avs_read, avs_write, avs_waitrequest;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic        master_reset_n, flush_reset_n, endian_fallthrough_select;
   logic [1:0]  offset_mode_select;
   logic        serial_offset_in, serial_offset_enable, portb_read_enable;
   logic        porta_select_n, porta_write_read, porta_enable;
   logic        porta_mailbox_select, bm, sz, be;
   logic [35:0] porta_data, portb_data;
   logic        empty_or_output_ready, full_or_input_ready;
   int          fails = 0, n_tests = 0, cycles = 0;

   bmf_fifo #(.DEPTH(256), .DEF_OFFSET(8)) u_bmf_fifo (
      .clk(clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .master_reset_n(master_reset_n), .flush_reset_n(flush_reset_n),
      .endian_fallthrough_select(endian_fallthrough_select),
      .offset_mode_select(offset_mode_select),
      .serial_offset_in(serial_offset_in),
      .serial_offset_enable(serial_offset_enable),
      .porta_select_n(porta_select_n), .porta_write_read(porta_write_read),
      .porta_enable(porta_enable),
      .porta_mailbox_select(porta_mailbox_select),
      .porta_data(porta_data), .portb_read_enable(portb_read_enable),
      .portb_data(portb_data),
      .empty_or_output_ready(empty_or_output_ready),
      .full_or_input_ready(full_or_input_ready)
   );
   bmf_porta_master u_bmf_porta_master (
      .clk(clk), .full_or_input_ready(full_or_input_ready),
      .porta_select_n(porta_select_n), .porta_write_read(porta_write_read),
      .porta_enable(porta_enable),
      .porta_mailbox_select(porta_mailbox_select),
      .porta_data(porta_data)
   );
   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // hang guard, far above the thousand or so cycles needed
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         fails++;
         final_report();
      end
   end
   task automatic final_report();
      $display("fails=%0d n_tests=%0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         fails++;
      end
   endtask
   // avalon access, held until an edge samples waitrequest low
   task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic mrst(input bit sel, input logic [1:0] pm);
      @(posedge clk);
      endian_fallthrough_select <= sel;
      offset_mode_select <= pm;
      master_reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      master_reset_n <= 1'b1;
      @(posedge clk);
   endtask
   task automatic wr(input logic [35:0] w, input bit h);
      @(posedge clk);
      u_bmf_porta_master.put(w, h);
   endtask
   task automatic waitf(input bit f);
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         if ((f ? full_or_input_ready : empty_or_output_ready) === 1'b1) break;
      end
      chk(f ? full_or_input_ready : empty_or_output_ready, 36'h1);
   endtask
   // flush while a word is held; the select steers the flag drop
   task automatic flush(input bit sel);
      wr(36'h9A5C3E1F7, 1'b1);
      waitf(1'b0);
      @(posedge clk);
      endian_fallthrough_select <= sel;
      flush_reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk(empty_or_output_ready, !sel);
      @(posedge clk);
      flush_reset_n <= 1'b1;
      waitf(1'b1);
   endtask
   // c back-to-back port b reads from the next edge on
   task automatic rd(input int c);
      portb_read_enable <= 1'b1;
      repeat (c) @(posedge clk);
      portb_read_enable <= 1'b0;
   endtask
   // write nw words, then read every unit back to back
   task automatic xfer(input int nw);
      int n, u, i;
      logic [35:0] w;
      n = bm ? (sz ? 4 : 2) : 1;
      u = 36 / n;
      for (int k = 0; k < nw; k++) wr(k ? 36'h1236C9ED5 : 36'h9A5C3E1F7, 1'b1);
      waitf(1'b0);
      portb_read_enable <= 1'b1;
      for (int k = 0; k <= n * nw; k++) begin
         @(posedge clk);
         if (k == n * nw - 1) portb_read_enable <= 1'b0;
         i = be ? k : k - 1;
         if (i >= 0 && i < n * nw) begin
            w = (i / n) ? 36'h1236C9ED5 : 36'h9A5C3E1F7;
            w = w >> ((be ? n - 1 - i % n : i % n) * u);
            chk(portb_data, w & ((36'h1 << u) - 36'h1));
         end
         chk(empty_or_output_ready, k < n * nw);
      end
   endtask
   initial begin
      rst = 1'b1;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      {master_reset_n, flush_reset_n, endian_fallthrough_select} = 3'h6;
      {offset_mode_select, serial_offset_in, serial_offset_enable} = '0;
      portb_read_enable = 1'b0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 4'hC, 32'h0);
      chk(q, 36'h0);
      // serial offsets with gaps; a write meanwhile must be dropped
      mrst(1'b0, 2'h1);
      wr(36'h9A5C3E1F7, 1'b0);
      for (int s = 15; s >= 0; s--) begin
         @(posedge clk);
         serial_offset_in <= 1'(16'hA53C >> s); // almost-full byte first
         serial_offset_enable <= 1'b1;
         @(posedge clk);
         serial_offset_enable <= 1'b0;
      end
      waitf(1'b1);
      bus(1'b0, bmf_pkg::BMF_OFFS_OFS, 32'h0);
      chk(q, 36'h00A5003C);
      chk(empty_or_output_ready, 36'h0);
      // parallel offsets through port a, not on consecutive edges
      mrst(1'b0, 2'h2);
      wr(36'h0000000C3, 1'b0);
      repeat (3) @(posedge clk);
      wr(36'h00000005A, 1'b0);
      waitf(1'b1);
      bus(1'b0, bmf_pkg::BMF_OFFS_OFS, 32'h0);
      chk(q, 36'h00C3005A);
      // every bus size in both endian and flag modes
      for (int b = 0; b < 2; b++) begin
         for (int m = 0; m < 3; m++) begin
            bm = m != 0;
            sz = m == 2;
            be = b[0];
            bus(1'b1, bmf_pkg::BMF_CTRL_OFS, {30'h0, sz, bm});
            mrst(be, 2'h0);
            waitf(1'b1);
            bus(1'b0, bmf_pkg::BMF_STAT_OFS, 32'h0);
            chk(q[3:2], {be, be});
            xfer(2);
         end
      end
      // flush with data held, fast then slow drop; latched modes survive
      flush(1'b1);
      flush(1'b0);
      bus(1'b0, bmf_pkg::BMF_STAT_OFS, 32'h0);
      chk(q, 36'h0000000E);
      xfer(1);
      // fill up; room returns only once the final byte has gone
      for (int k = 0; k < 256; k++) wr(36'h1236C9ED5, 1'b1);
      @(posedge clk);
      chk(full_or_input_ready, 36'h0);
      bus(1'b0, bmf_pkg::BMF_STAT_OFS, 32'h0);
      chk(q, 36'h0100000D);
      rd(2);
      repeat (6) @(posedge clk);
      chk(full_or_input_ready, 36'h0);
      rd(2);
      waitf(1'b1);
      final_report();
   end
endmodule
`default_nettype wire
